/* verilog/pic_pkg.sv */
// Purpose: shared constants and types for the interval counter
// Assumes: one 16-bit down counter, single system clock
// Notes:   count clock, gate and write strobes are synchronous to CLK

// ============================================================
// constants and types
package pic_pkg;

  localparam int CNT_W      = 16;
  localparam int DIGIT_W    = 4;
  localparam int BCD_DIGITS = 4;
  localparam int MODE_HI    = 2;  // op_mode_select_hi bit position

  // byte_access_field encodings
  localparam logic [1:0] BA_LATCH = 2'h0;
  localparam logic [1:0] BA_LSB   = 2'h1;
  localparam logic [1:0] BA_MSB   = 2'h2;
  localparam logic [1:0] BA_BOTH  = 2'h3;

  // decrement steps
  localparam logic [1:0] STEP_ONE   = 2'h1;
  localparam logic [1:0] STEP_TWO   = 2'h2;
  localparam logic [1:0] STEP_THREE = 2'h3;

  localparam logic [CNT_W-1:0]   CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0]   CNT_TWO  = 16'h0002;
  localparam logic [CNT_W-1:0]   CNT_RST  = 16'h0000;
  localparam logic [DIGIT_W:0]   BCD_TEN  = 5'h0A;
  localparam logic [7:0]         BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    PIC_MODE0 = 3'h0,  // interrupt on terminal count
    PIC_MODE1 = 3'h1,  // retriggerable one-shot
    PIC_MODE2 = 3'h2,  // rate generator
    PIC_MODE3 = 3'h3,  // square wave
    PIC_MODE4 = 3'h4,  // software strobe
    PIC_MODE5 = 3'h5   // hardware strobe
  } pic_mode_e;

  // count load sequence, gray coded along the normal path
  typedef enum logic [1:0] {
    LD_IDLE     = 2'b00,
    LD_WAIT_MSB = 2'b01,
    LD_PEND     = 2'b11,
    LD_ARMED    = 2'b10
  } pic_load_e;

endpackage : pic_pkg

/* verilog/pic_dec_if.sv */
// Purpose: carrier between the counter and its decrement unit
// Assumes: purely combinational use
// Notes:   step is 1, 2 or 3

// ============================================================
// decrement request and result
interface pic_dec_if;
  import pic_pkg::*;

  logic [CNT_W-1:0] value;   // current count
  logic             bcd;     // four-decade decimal when high
  logic [1:0]       step;    // amount to subtract
  logic [CNT_W-1:0] result;  // wrapped difference

  modport user (output value, output bcd, output step, input result);
  modport unit (input value, input bcd, input step, output result);

endinterface : pic_dec_if

/* verilog/pic_dec.sv */
// Purpose: subtract 1..3 from the count in binary or decimal
// Assumes: decimal operand holds valid digits
// Notes:   both encodings wrap below zero (0 - 1 gives all nines in decimal, all ones in binary)

// ============================================================
// decrement unit
module pic_dec
  import pic_pkg::*;
(
  pic_dec_if.unit dec  // request and result
);

  logic [BCD_DIGITS:0] borrow;
  logic [CNT_W-1:0]    bcd_res;

  assign borrow[0] = 1'b0;

  // one digit stage per decade, borrow ripples upward
  for (genvar i = 0; i < BCD_DIGITS; i++)
  begin : g_digit
    logic [DIGIT_W:0] sub;
    logic [DIGIT_W:0] diff;
    assign sub  = (i == 0) ? {3'b000, dec.step} : '0;
    assign diff = {1'b0, dec.value[i*DIGIT_W +: DIGIT_W]} - sub - {4'b0000, borrow[i]};
    assign borrow[i+1] = diff[DIGIT_W];
    assign bcd_res[i*DIGIT_W +: DIGIT_W] = diff[DIGIT_W] ? DIGIT_W'(diff + BCD_TEN)
                                                          : diff[DIGIT_W-1:0];
  end

  assign dec.result = dec.bcd ? bcd_res : CNT_W'(dec.value - {14'b0, dec.step});

endmodule : pic_dec

/* verilog/pic_counter.sv */
// Purpose: one presettable 16-bit down counter with six modes
// Assumes: CNT_CLK and GATE are synchronous to CLK and much slower
// Notes:   counting happens on sampled falling edges of CNT_CLK
//
// Overview of operation
// - mode 0: output low after set, counting
// - mode 0: high at terminal count until rewritten
// - mode 0: keeps decrementing past terminal count
// - mode 0: first byte halts, second restarts
// - mode 1: gate rise drops output, TC raises
// - mode 1: new count waits for next trigger
// - mode 1: each gate rise retriggers full count
// - mode 1: count readable without disturbing pulse
// - mode 2: divide by N, one-clock low
// - modes 2,3: reload waits for period end (mode 2) or half-period end (mode 3)
// - mode 2: gate low forces high, rise restarts
// - mode 2: output high until count loaded
// - mode 3 even: step two, toggle, reload
// - mode 3 odd: steps one/three, unequal halves
// - mode 4: load starts count, one-clock strobe
// - mode 4: low gate suspends counting
// - mode 4: reload restarts with new value
// - mode 5: gate rise starts, one-clock strobe
// - mode 5: retrigger restarts full count
// - mode field selects 0-5, top bit ignored when bit 1 is set (6, 7 act as 2, 3)
// - count enters after rise then fall

// ============================================================
// counter top
module pic_counter
  import pic_pkg::*;
(
  input  wire logic             CLK,                // system clock
  input  wire logic             RST_B,              // async reset, active low
  input  wire logic             MODE_WR,            // control word write strobe
  input  wire logic [2:0]       MODE_SEL,           // operating mode field
  input  wire logic             BCD_SEL,            // decimal counting select
  input  wire logic [1:0]       BYTE_ACCESS_FIELD,  // count byte load order
  input  wire logic             DATA_WR,            // count byte write strobe
  input  wire logic [7:0]       DATA_IN,            // count byte
  input  wire logic             CNT_CLK,            // count clock input
  input  wire logic             GATE,               // gate or trigger input
  output logic                  OUT,                // counter output
  output logic [CNT_W-1:0]      COUNT,              // live count value
  output logic                  NULL_COUNT          // written count not yet in use
);

  // ============================================================
  // declarations
  pic_mode_e        mode;
  pic_mode_e        next_mode;
  pic_load_e        ld_state;
  logic             bcd;
  logic [1:0]       byte_access_field;
  logic             cnt_clk_q;
  logic             gate_q;
  logic             clk_rise;
  logic             clk_fall;
  logic             gate_rise;
  logic             trig;
  logic             load_now;
  logic             halt;
  logic             running;
  logic             strobe_used;
  logic             out;
  logic             mode_set;
  logic [CNT_W-1:0] staged;
  logic [CNT_W-1:0] cr;
  logic [CNT_W-1:0] cr_val;
  logic [CNT_W-1:0] ce;
  logic [1:0]       step;
  logic             sq_tc;
  logic             gated_mode;

  pic_dec_if dec_bus ();

  // ============================================================
  // decrement unit
  pic_dec u_dec (
    .dec (dec_bus.unit)
  );

  assign dec_bus.value = ce;
  assign dec_bus.bcd   = bcd;
  assign dec_bus.step  = step;

  // odd count: first high-phase clock takes one, first low-phase clock takes three
  always_comb
  begin
    step = STEP_ONE;
    if (mode == PIC_MODE3)
    begin
      if (!ce[0])
        step = STEP_TWO;
      else if (out)
        step = STEP_ONE;
      else
        step = STEP_THREE;
    end
  end

  assign sq_tc = (ce == {14'b0, step});

  // ============================================================
  // edge detection
  // inputs are synchronous, so a single sample register is enough
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cnt_clk_q <= 1'b0;
      gate_q    <= 1'b0;
    end
    else
    begin
      cnt_clk_q <= CNT_CLK;
      gate_q    <= GATE;
    end
  end

  assign clk_rise  = CNT_CLK & ~cnt_clk_q;
  assign clk_fall  = ~CNT_CLK & cnt_clk_q;
  assign gate_rise = GATE & ~gate_q;

  // a gate rise is held until the next counting edge consumes it;
  // a rise in the consuming cycle is kept
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      trig <= 1'b0;
    else if (mode_set)
      trig <= gate_rise;
    else
      trig <= gate_rise | (trig & ~clk_fall);
  end

  // ============================================================
  // control word
  // the latch command shares the strobe and is not a mode set
  assign mode_set = MODE_WR & (BYTE_ACCESS_FIELD != BA_LATCH);

  always_comb
  begin
    if (MODE_SEL[1])
      next_mode = pic_mode_e'({1'b0, MODE_SEL[1:0]});
    else
      next_mode = pic_mode_e'(MODE_SEL);
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mode              <= PIC_MODE0;
      bcd               <= 1'b0;
      byte_access_field <= BA_LSB;
    end
    else if (mode_set)
    begin
      mode              <= next_mode;
      bcd               <= BCD_SEL;
      byte_access_field <= BYTE_ACCESS_FIELD;
    end
  end

  // ============================================================
  // count byte loading
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ld_state <= LD_IDLE;
      staged   <= CNT_RST;
    end
    else if (mode_set)
      ld_state <= LD_IDLE;
    else if (DATA_WR)
    begin
      case (byte_access_field)
        BA_LSB:
        begin
          staged   <= {BYTE_ZERO, DATA_IN};
          ld_state <= LD_PEND;
        end
        BA_MSB:
        begin
          staged   <= {DATA_IN, BYTE_ZERO};
          ld_state <= LD_PEND;
        end
        BA_BOTH:
        begin
          if (ld_state == LD_WAIT_MSB)
          begin
            staged[15:8] <= DATA_IN;
            ld_state     <= LD_PEND;
          end
          else
          begin
            staged[7:0] <= DATA_IN;
            ld_state    <= LD_WAIT_MSB;
          end
        end
        default:
          ld_state <= ld_state;
      endcase
    end
    else
    begin
      case (ld_state)
        LD_PEND:
          if (clk_rise)
            ld_state <= LD_ARMED;
        LD_ARMED:
          if (clk_fall)
            ld_state <= LD_IDLE;
        default:
          ld_state <= ld_state;
      endcase
    end
  end

  // a second write in the armed window restarts the sequence, so load_now
  // never fires on a half-written value
  assign load_now   = (ld_state == LD_ARMED) & clk_fall & ~DATA_WR & ~mode_set;
  assign cr_val     = load_now ? staged : cr;
  assign NULL_COUNT = (ld_state != LD_IDLE);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      cr <= CNT_RST;
    else if (load_now)
      cr <= staged;
  end

  // first byte of a two-byte rewrite freezes a mode 0 count
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      halt <= 1'b0;
    else if (mode_set || load_now)
      halt <= 1'b0;
    else if (DATA_WR && mode == PIC_MODE0 && byte_access_field == BA_BOTH && ld_state != LD_WAIT_MSB)
      halt <= 1'b1;
  end

  // ============================================================
  // mode engine
  assign gated_mode = (mode == PIC_MODE2) || (mode == PIC_MODE3);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      out         <= 1'b1;
      ce          <= CNT_RST;
      running     <= 1'b0;
      strobe_used <= 1'b1;
    end
    else if (mode_set)
    begin
      out         <= (next_mode != PIC_MODE0);
      running     <= 1'b0;
      strobe_used <= 1'b1;
    end
    // a first load under a low gate must still arm the counter, or the gate rise finds nothing to restart
    else if (gated_mode && !GATE && !(load_now && !running))
      out <= 1'b1;
    else if (clk_fall)
    begin
      case (mode)
        PIC_MODE0:
        begin
          if (load_now)
          begin
            ce      <= staged;
            out     <= 1'b0;
            running <= 1'b1;
          end
          else if (running && !halt)
          begin
            ce <= dec_bus.result;
            if (ce == CNT_ONE)
              out <= 1'b1;
          end
        end
        PIC_MODE1:
        begin
          // a load only updates cr; the pulse in flight keeps its length
          if (trig)
          begin
            ce      <= cr_val;
            out     <= 1'b0;
            running <= 1'b1;
          end
          else if (running)
          begin
            ce <= dec_bus.result;
            if (ce == CNT_ONE)
              out <= 1'b1;
          end
        end
        PIC_MODE2:
        begin
          if (load_now && !running)
          begin
            ce      <= staged;
            out     <= 1'b1;
            running <= 1'b1;
          end
          else if (trig && running)
          begin
            ce  <= cr_val;
            out <= 1'b1;
          end
          else if (running)
          begin
            if (ce == CNT_ONE)
            begin
              ce  <= cr_val;
              out <= 1'b1;
            end
            else
            begin
              ce  <= dec_bus.result;
              out <= (ce != CNT_TWO);
            end
          end
        end
        PIC_MODE3:
        begin
          if (load_now && !running)
          begin
            ce      <= staged;
            out     <= 1'b1;
            running <= 1'b1;
          end
          else if (trig && running)
          begin
            ce  <= cr_val;
            out <= 1'b1;
          end
          else if (running)
          begin
            if (sq_tc)
            begin
              ce  <= cr_val;
              out <= ~out;
            end
            else
              ce <= dec_bus.result;
          end
        end
        PIC_MODE4:
        begin
          if (load_now)
          begin
            ce          <= staged;
            out         <= 1'b1;
            running     <= 1'b1;
            strobe_used <= 1'b0;
          end
          else if (running && GATE)
          begin
            ce <= dec_bus.result;
            if (ce == CNT_ONE && !strobe_used)
            begin
              out         <= 1'b0;
              strobe_used <= 1'b1;
            end
            else
              out <= 1'b1;
          end
          else
            out <= 1'b1;
        end
        PIC_MODE5:
        begin
          if (trig)
          begin
            ce          <= cr_val;
            out         <= 1'b1;
            running     <= 1'b1;
            strobe_used <= 1'b0;
          end
          else if (running)
          begin
            ce <= dec_bus.result;
            if (ce == CNT_ONE && !strobe_used)
            begin
              out         <= 1'b0;
              strobe_used <= 1'b1;
            end
            else
              out <= 1'b1;
          end
        end
        default:
          out <= 1'b1;
      endcase
    end
  end

  // ============================================================
  // outputs
  // count is the live element, sampled at any time without side effects
  assign OUT   = out;
  assign COUNT = ce;

endmodule : pic_counter

/* sim/pic_counter_props.sv */
// Purpose: port-level assertions for the interval counter
// Assumes: count clock and gate are synchronous to CLK
// Notes:   a fall is a CLK cycle with CNT_CLK low after a high sample

// ============================================================
// checker
module pic_counter_props
  import pic_pkg::*;
(
  input wire logic             CLK,                // system clock
  input wire logic             RST_B,              // async reset, active low
  input wire logic             MODE_WR,            // control word strobe
  input wire logic [2:0]       MODE_SEL,           // mode field
  input wire logic             BCD_SEL,            // decimal select
  input wire logic [1:0]       BYTE_ACCESS_FIELD,  // byte load order
  input wire logic             DATA_WR,            // count byte strobe
  input wire logic [7:0]       DATA_IN,            // count byte
  input wire logic             CNT_CLK,            // count clock
  input wire logic             GATE,               // gate or trigger
  input wire logic             OUT,                // counter output
  input wire logic [CNT_W-1:0] COUNT,              // live count
  input wire logic             NULL_COUNT          // count pending
);
  logic       cnt_q;
  logic       mw_q;
  logic       nc_q;
  logic       run;
  logic       bcd;
  logic [2:0] mode;
  logic       mw;
  logic       fall;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  assign mw   = MODE_WR && (BYTE_ACCESS_FIELD != BA_LATCH);
  assign fall = cnt_q && !CNT_CLK;

  // run is set only by a real transfer, so a stale count after a mode set is not mistaken for counting
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
    begin
      cnt_q <= 1'b0;
      mw_q  <= 1'b0;
      nc_q  <= 1'b0;
      run   <= 1'b0;
      bcd   <= 1'b0;
      mode  <= 3'h0;
    end
    else
    begin
      cnt_q <= CNT_CLK;
      mw_q  <= mw;
      nc_q  <= NULL_COUNT;
      run   <= mw ? 1'b0 : (run || (nc_q && !NULL_COUNT && !mw_q));
      bcd   <= mw ? BCD_SEL : bcd;
      mode  <= !mw ? mode : (MODE_SEL[1] ? {1'b0, MODE_SEL[1:0]} : MODE_SEL);
    end

  property p_m0_low;
    mw && MODE_SEL == 3'h0 |=> !OUT;
  endproperty
  a_m0_low: assert property (p_m0_low) else $error("mode 0 set left output high");
  property p_set_high;
    mw && MODE_SEL != 3'h0 |=> OUT;
  endproperty
  a_set_high: assert property (p_set_high) else $error("mode set left output low");
  property p_null_rise;
    DATA_WR && !MODE_WR && !fall |=> NULL_COUNT;
  endproperty
  a_null_rise: assert property (p_null_rise) else $error("count byte did not flag pending");
  property p_null_hold;
    NULL_COUNT && !fall && !MODE_WR |=> NULL_COUNT;
  endproperty
  a_null_hold: assert property (p_null_hold) else $error("pending flag cleared without fall");
  property p_m0_tc;
    mode == 3'h0 && run && fall && COUNT == CNT_ONE && !NULL_COUNT && !DATA_WR && !MODE_WR |=> OUT;
  endproperty
  a_m0_tc: assert property (p_m0_tc) else $error("terminal count did not raise output");
  property p_m0_stay;
    mode == 3'h0 && OUT && !mw && !(fall && NULL_COUNT) |=> OUT;
  endproperty
  a_m0_stay: assert property (p_m0_stay) else $error("mode 0 output dropped early");
  property p_m0_dec;
    mode == 3'h0 && run && !bcd && fall && !NULL_COUNT && !DATA_WR && !MODE_WR |=> COUNT == $past(COUNT) - CNT_ONE;
  endproperty
  a_m0_dec: assert property (p_m0_dec) else $error("mode 0 count did not step by one");
  property p_rate_pulse;
    mode == 3'h2 && !OUT && fall && !MODE_WR |=> OUT;
  endproperty
  a_rate_pulse: assert property (p_rate_pulse) else $error("rate pulse longer than one count");
  property p_gate_force;
    mode[1] && !GATE && !mw |=> OUT;
  endproperty
  a_gate_force: assert property (p_gate_force) else $error("low gate did not force output high");
  property p_strobe;
    mode[2] && !OUT && fall && !MODE_WR |=> OUT;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe longer than one count");
  property p_m4_hold;
    mode == 3'h4 && !GATE && run && fall && !NULL_COUNT && !DATA_WR && !MODE_WR |=> $stable(COUNT);
  endproperty
  a_m4_hold: assert property (p_m4_hold) else $error("count moved with gate low");
endmodule : pic_counter_props

bind pic_counter pic_counter_props i_props (
  .CLK(CLK), .RST_B(RST_B), .MODE_WR(MODE_WR), .MODE_SEL(MODE_SEL), .BCD_SEL(BCD_SEL),
  .BYTE_ACCESS_FIELD(BYTE_ACCESS_FIELD), .DATA_WR(DATA_WR), .DATA_IN(DATA_IN), .CNT_CLK(CNT_CLK),
  .GATE(GATE), .OUT(OUT), .COUNT(COUNT), .NULL_COUNT(NULL_COUNT)
);

/* sim/pic_cpu_model.sv */
// Purpose: processor side that writes control words and count bytes
// Assumes: strobes are one-cycle pulses taken at CLK rise
// Notes:   released qualifiers show inverted data, except BYTE_ACCESS_FIELD, which keeps its last value

// ============================================================
// processor model
module pic_cpu_model
  import pic_pkg::*;
(
  input  wire logic CLK,                // system clock
  output logic       MODE_WR,           // control word strobe
  output logic [2:0] MODE_SEL,          // mode field
  output logic       BCD_SEL,           // decimal select
  output logic [1:0] BYTE_ACCESS_FIELD, // byte load order
  output logic       DATA_WR,           // count byte strobe
  output logic [7:0] DATA_IN            // count byte
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    MODE_WR           = 1'b0;
    MODE_SEL          = 3'h0;
    BCD_SEL           = 1'b0;
    BYTE_ACCESS_FIELD = BA_LSB;
    DATA_WR           = 1'b0;
    DATA_IN           = BYTE_ZERO;
  end

  task automatic wr_mode(input logic [2:0] sel, input logic bcd, input logic [1:0] acc);
    @(posedge CLK);
    MODE_WR           <= 1'b1;
    MODE_SEL          <= sel;
    BCD_SEL           <= bcd;
    BYTE_ACCESS_FIELD <= acc;
    @(posedge CLK);
    MODE_WR           <= 1'b0;
    MODE_SEL          <= ~sel;
    BCD_SEL           <= ~bcd;
  endtask : wr_mode

  task automatic wr_byte(input logic [7:0] b);
    @(posedge CLK);
    DATA_WR <= 1'b1;
    DATA_IN <= b;
    @(posedge CLK);
    DATA_WR <= 1'b0;
    DATA_IN <= ~b;
  endtask : wr_byte

  // low byte goes first when both are loaded
  task automatic wr_count(input logic [1:0] acc, input logic [15:0] v);
    if (acc != BA_MSB)
      wr_byte(v[7:0]);
    if (acc != BA_LSB)
      wr_byte(v[15:8]);
  endtask : wr_count
endmodule : pic_cpu_model

/* sim/pic_counter_test.sv */
// Purpose: self-checking bench for the six counting modes
// Assumes: count clock made here, 2 CLK high and 2 CLK low per period
// Notes:   output edges are checked against the count clock fall index

// ============================================================
// bench top
module pic_counter_test
  import pic_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic             CLK = 1'b0;
  logic             RST_B;
  logic             MODE_WR;
  logic [2:0]       MODE_SEL;
  logic             BCD_SEL;
  logic [1:0]       BYTE_ACCESS_FIELD;
  logic             DATA_WR;
  logic [7:0]       DATA_IN;
  logic             CNT_CLK;
  logic             GATE;
  logic             OUT;
  logic [CNT_W-1:0] COUNT;
  logic             NULL_COUNT;
  int               error_cnt = 0;
  int               num_checks = 0;
  int               fall_no = 0;
  logic             cur_lvl = 1'b1;
  logic             prv = 1'b1;
  logic             exp_lvl[$];
  int               exp_at[$];

  always #10 CLK = ~CLK;

  pic_counter i_dut (.CLK(CLK), .RST_B(RST_B), .MODE_WR(MODE_WR), .MODE_SEL(MODE_SEL), .BCD_SEL(BCD_SEL),
    .BYTE_ACCESS_FIELD(BYTE_ACCESS_FIELD), .DATA_WR(DATA_WR), .DATA_IN(DATA_IN), .CNT_CLK(CNT_CLK),
    .GATE(GATE), .OUT(OUT), .COUNT(COUNT), .NULL_COUNT(NULL_COUNT));
  pic_cpu_model i_cpu (.CLK(CLK), .MODE_WR(MODE_WR), .MODE_SEL(MODE_SEL), .BCD_SEL(BCD_SEL),
    .BYTE_ACCESS_FIELD(BYTE_ACCESS_FIELD), .DATA_WR(DATA_WR), .DATA_IN(DATA_IN));

  task automatic check(input string what, input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // only level changes are noted, so the monitor sees exactly one note per edge
  task automatic exp_out(input logic v, input int f);
    if (v !== cur_lvl)
    begin
      exp_lvl.push_back(v);
      exp_at.push_back(f);
    end
    cur_lvl = v;
  endtask : exp_out

  task automatic pulse(input int n);
    repeat (n)
    begin
      CNT_CLK <= 1'b1;
      repeat (2) @(posedge CLK);
      CNT_CLK <= 1'b0;
      fall_no++;
      repeat (2) @(posedge CLK);
    end
  endtask : pulse

  // sampled mid-cycle so the fall index and the output are both settled
  always @(negedge CLK)
    if (RST_B === 1'b1 && OUT !== prv)
    begin
      if (exp_lvl.size() == 0)
        check("unexpected out edge", {15'h0000, OUT}, {15'h0000, prv});
      else
      begin
        check("out level", {15'h0000, OUT}, {15'h0000, exp_lvl.pop_front()});
        check("out fall", 16'(fall_no), 16'(exp_at.pop_front()));
      end
      prv = OUT;
    end

  initial
  begin
    repeat (100000) @(posedge CLK);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    int         n;
    int         b;
    logic [2:0] sels[5];
    logic [2:0] pair[2];
    sels = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    pair = '{3'h1, 3'h5};
    RST_B   = 1'b0;
    CNT_CLK = 1'b0;
    GATE    = 1'b1;
    void'($urandom(32'h0000_f3ed));
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    exp_out(1'b0, fall_no);
    i_cpu.wr_mode(3'h0, 1'b0, BA_BOTH);
    n = 3 + $urandom % 4;
    i_cpu.wr_count(BA_BOTH, 16'(n));
    check("pending set", {15'h0000, NULL_COUNT}, 16'h0001);
    pulse(1);
    check("mode0 load", COUNT, 16'(n));
    check("pending clear", {15'h0000, NULL_COUNT}, 16'h0000);
    pulse(2);
    i_cpu.wr_byte(8'h04);
    pulse(3);
    check("halted count", COUNT, 16'(n - 2));
    i_cpu.wr_byte(8'h00);
    pulse(1);
    check("new count", COUNT, 16'h0004);
    exp_out(1'b1, fall_no + 4);
    pulse(7);
    check("wrapped count", COUNT, 16'hfffd);
    $display("test mode0 done");
    exp_out(1'b0, fall_no);
    i_cpu.wr_mode(3'h0, 1'b1, BA_MSB);
    i_cpu.wr_count(BA_MSB, 16'h0100);
    pulse(2);
    check("decimal msb", COUNT, 16'h0099);
    i_cpu.wr_mode(3'h0, 1'b1, BA_LSB);
    i_cpu.wr_count(BA_LSB, 16'h0010);
    pulse(4);
    check("decimal lsb", COUNT, 16'h0007);
    i_cpu.wr_mode(3'h2, 1'b0, BA_LATCH);
    pulse(1);
    check("latch ignored", COUNT, 16'h0006);
    $display("test decimal done");
    foreach (sels[i])
    begin
      n = 3 + $urandom % 4;
      if (sels[i] == 3'h3)
        n = n & ~1;
      if (sels[i] == 3'h7)
        n = n | 1;
      exp_out(1'b1, fall_no);
      i_cpu.wr_mode(sels[i], 1'b0, BA_LSB);
      i_cpu.wr_count(BA_LSB, 16'(n));
      b = fall_no + 1;
      for (int p = 0; p < 2; p++)
        if (sels[i][1] || p == 0)
        begin
          exp_out(1'b0, b + p * n + (sels[i][1] ? (sels[i][0] ? (n + 1) / 2 : n - 1) : n));
          exp_out(1'b1, b + p * n + (sels[i][1] ? n : n + 1));
        end
      pulse(2 * n + 1);
    end
    $display("test periodic modes done");
    i_cpu.wr_mode(3'h2, 1'b0, BA_LSB);
    i_cpu.wr_count(BA_LSB, 16'h0004);
    b = fall_no + 1;
    pulse(2);
    i_cpu.wr_count(BA_LSB, 16'h0003);
    exp_out(1'b0, b + 3);
    exp_out(1'b1, b + 4);
    exp_out(1'b0, b + 6);
    exp_out(1'b1, b + 7);
    exp_out(1'b0, b + 11);
    exp_out(1'b1, b + 12);
    pulse(6);
    GATE <= 1'b0;
    pulse(1);
    GATE <= 1'b1;
    pulse(4);
    $display("test rate gate done");
    foreach (pair[i])
    begin
      GATE <= 1'b0;
      i_cpu.wr_mode(pair[i], 1'b0, BA_LSB);
      i_cpu.wr_count(BA_LSB, 16'h0003);
      pulse(1);
      GATE <= 1'b1;
      b = fall_no + 1;
      if (!pair[i][2])
        exp_out(1'b0, b);
      exp_out(1'b0, b + 5);
      exp_out(1'b1, b + (pair[i][2] ? 6 : 5));
      pulse(1);
      GATE <= 1'b0;
      pulse(1);
      check("running count", COUNT, 16'h0002);
      GATE <= 1'b1;
      pulse(5);
    end
    $display("test triggered modes done");
    GATE <= 1'b0;
    i_cpu.wr_mode(3'h4, 1'b0, BA_LSB);
    i_cpu.wr_count(BA_LSB, 16'h0003);
    pulse(4);
    check("gated count", COUNT, 16'h0003);
    GATE <= 1'b1;
    i_cpu.wr_count(BA_LSB, 16'h0002);
    b = fall_no + 1;
    exp_out(1'b0, b + 2);
    exp_out(1'b1, b + 3);
    pulse(4);
    $display("test strobe reload done");
    check("notes left", 16'(exp_lvl.size()), 16'h0000);
    end_of_test();
  end
endmodule : pic_counter_test
